// ===== design/acci_counter_compare_irq.sv
// Axis position counters, comparators, sync select and event interrupt masking
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module acci_axis_cnt
	import acci_pkg::*;
(
	// Clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// Control
	input  wire acci_step_t    step,
	input  wire logic          hold,
	input  wire logic          ring,
	input  wire logic          clr_on_latch,
	input  wire logic          latch_trig,
	input  wire logic          home_trig,
	input  wire logic [1:0]    method,
	// Host writes
	input  wire logic          cnt_wr,
	input  wire logic          cmp_wr,
	input  wire logic [CW-1:0] wr_data,
	// State
	output logic [CW-1:0]      cnt_q,
	output logic [CW-1:0]      cmp_q,
	output logic [CW-1:0]      ltc_q,
	output logic               met,
	output logic               met_rise
);
	logic [CW-1:0] cnt_d;
	logic          met_q;
	wire           up    = step.up & ~step.down;
	wire           down  = step.down & ~step.up;
	wire           at_top = cnt_q == cmp_q;
	wire           at_zero = cnt_q == '0;
	wire [CW-1:0]  plus  = (ring & at_top) ? '0 : cnt_q + 1'b1;
	wire [CW-1:0]  minus = (ring & at_zero) ? cmp_q : cnt_q - 1'b1;
	wire [CW-1:0]  stepped = up ? plus : (down ? minus : cnt_q);
	wire           eq = cnt_q == cmp_q;
	wire           gt = $signed(cmp_q) > $signed(cnt_q);
	wire           lt = $signed(cmp_q) < $signed(cnt_q);

	// Host write beats latch clear beats counting, so software always sees its value
	always_comb begin
		if (cnt_wr)
			cnt_d = wr_data;
		else if (home_trig)
			cnt_d = '0;
		else if (latch_trig & clr_on_latch)
			cnt_d = '0;
		else if (hold)
			cnt_d = cnt_q;
		else
			cnt_d = stepped;
	end

	always_comb begin
		case (method)
			CMP_EQ:  met = eq;
			CMP_GT:  met = gt;
			CMP_LT:  met = lt;
			default: met = 1'b0;
		endcase
	end

	assign met_rise = met & ~met_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
			cmp_q <= '0;
			ltc_q <= '0;
			met_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			if (cmp_wr)
				cmp_q <= wr_data;
			if (latch_trig | home_trig)
				ltc_q <= cnt_q;
			met_q <= met;
		end
	end

	AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		hold & ~cnt_wr & ~home_trig & ~(latch_trig & clr_on_latch) |=> $stable(cnt_q))
		else $error("held counter moved");
	AST_CLR_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
		latch_trig & clr_on_latch & ~cnt_wr |=> cnt_q == '0 && ltc_q == $past(cnt_q))
		else $error("latch with clear wrong");
	AST_HOME: assert property (@(posedge pclk) disable iff (!presetn)
		home_trig & ~cnt_wr |=> cnt_q == '0 && ltc_q == $past(cnt_q))
		else $error("home latch did not clear");
	AST_RING: assert property (@(posedge pclk) disable iff (!presetn)
		ring & up & at_top & ~hold & ~cnt_wr & ~home_trig & ~latch_trig |=> cnt_q == '0)
		else $error("ring did not wrap");
	AST_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		cnt_wr |=> cnt_q == $past(wr_data))
		else $error("counter write lost");
	AST_CMP_EQ: assert property (@(posedge pclk) disable iff (!presetn)
		method == CMP_EQ && cnt_q == cmp_q |-> met ##1 (met_q && !met_rise))
		else $error("equal compare missed");
endmodule

module acci_counter_compare_irq
	import acci_pkg::*;
(
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Count sources from pulse generator and encoder decoder
	input  wire acci_step_t  out_pulse_step,
	input  wire acci_step_t  encoder_inputs,
	// Motion events and sequencing
	input  wire acci_motion_ev_t motion_ev,
	input  wire logic        home_return_done,
	input  wire logic        latch_command,
	// Asynchronous pins
	input  wire logic        external_latch_input,
	input  wire logic        home_sensor_input,
	input  wire logic        slowdown_input,
	input  wire logic        simultaneous_start_input,
	input  wire logic [1:0]  pulser_inputs,
	input  wire logic        pulser_enable_pin,
	// Synchronous signal between axes
	input  wire logic [3:0]  sync_from_axes,
	output logic             sync_out,
	output logic             sync_in_used,
	// Event interrupt
	output logic             irq
);
	logic [ENV_W-1:0] env_q;
	logic [MSK_W-1:0] mask_q, cause_q, cause_d, ev;
	logic [PINS-1:0]  s1_q, s2_q, s3_q, pin_q, pin_d;
	logic [CW-1:0]    cnt1, cnt2, cmp1, cmp2, ltc1, ltc2;
	logic             met1, met2, rise1, rise2, sync_d;
	logic [31:0]      rd_d, prdata_q;
	logic             sync_out_q, sync_in_q;
	acci_step_t       step1, step2;

	// APB decode; zero wait states, read data captured in the setup cycle
	wire setup  = psel & ~penable;
	wire access = psel & penable;
	wire wr     = access & pwrite;
	wire rd     = access & ~pwrite;
	wire h_env  = paddr == OFS_ENV;
	wire h_cnt1 = paddr == OFS_CNT1;
	wire h_cnt2 = paddr == OFS_CNT2;
	wire h_cmp1 = paddr == OFS_CMP1;
	wire h_cmp2 = paddr == OFS_CMP2;
	wire h_mask = paddr == OFS_MASK;
	wire h_ltc1 = paddr == OFS_LTC1;
	wire h_ltc2 = paddr == OFS_LTC2;
	wire h_caus = paddr == OFS_CAUS;
	wire hit    = h_env | h_cnt1 | h_cnt2 | h_cmp1 | h_cmp2 | h_mask | h_ltc1 | h_ltc2 | h_caus;
	wire ro_hit = h_ltc1 | h_ltc2 | h_caus;
	assign pready  = 1'b1;
	assign pslverr = access & (~hit | (pwrite & ro_hit));
	assign prdata  = prdata_q;

	// Pins: three flops, a level counts once the second and third agree
	wire [PINS-1:0] pins_in = {pulser_enable_pin, pulser_inputs[1], pulser_inputs[0],
		simultaneous_start_input, slowdown_input, home_sensor_input, external_latch_input};
	assign pin_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & pin_q);
	wire [PINS-1:0] pin_rise = pin_d & ~pin_q;
	wire [PINS-1:0] pin_chg  = pin_d ^ pin_q;

	// Source selects have opposite polarity on the two counters
	assign step1 = env_q[F_SRC1] ? encoder_inputs : out_pulse_step;
	assign step2 = env_q[F_SRC2] ? out_pulse_step : encoder_inputs;

	wire dis1 = env_q[F_DIS1];
	wire dis2 = env_q[F_DIS2];
	wire hom1 = env_q[F_HOM1];
	wire hom2 = env_q[F_HOM2];
	wire ltc_trig1 = (pin_rise[P_LTC] & ~dis1) | latch_command;
	wire ltc_trig2 = (pin_rise[P_LTC] & ~dis2) | latch_command;

	acci_axis_cnt u_cnt1 (
		.pclk         (pclk),
		.presetn      (presetn),
		.step         (step1),
		.hold         (env_q[F_HLD1]),
		.ring         (env_q[F_RNG1]),
		.clr_on_latch (env_q[F_CLR1]),
		.latch_trig   (ltc_trig1),
		.home_trig    (home_return_done & hom1),
		.method       (env_q[F_MTH1+:2]),
		.cnt_wr       (wr & h_cnt1),
		.cmp_wr       (wr & h_cmp1),
		.wr_data      (pwdata[CW-1:0]),
		.cnt_q        (cnt1),
		.cmp_q        (cmp1),
		.ltc_q        (ltc1),
		.met          (met1),
		.met_rise     (rise1)
	);

	acci_axis_cnt u_cnt2 (
		.pclk         (pclk),
		.presetn      (presetn),
		.step         (step2),
		.hold         (env_q[F_HLD2]),
		.ring         (env_q[F_RNG2]),
		.clr_on_latch (env_q[F_CLR2]),
		.latch_trig   (ltc_trig2),
		.home_trig    (home_return_done & hom2),
		.method       (env_q[F_MTH2+:2]),
		.cnt_wr       (wr & h_cnt2),
		.cmp_wr       (wr & h_cmp2),
		.wr_data      (pwdata[CW-1:0]),
		.cnt_q        (cnt2),
		.cmp_q        (cmp2),
		.ltc_q        (ltc2),
		.met          (met2),
		.met_rise     (rise2)
	);

	// Event causes
	assign ev[E_STOP]  = motion_ev.normal_stop;
	assign ev[E_PREG]  = motion_ev.prereg_free;
	assign ev[2]       = motion_ev.accel_begin;
	assign ev[3]       = motion_ev.accel_finish;
	assign ev[4]       = motion_ev.decel_begin;
	assign ev[5]       = motion_ev.decel_finish;
	assign ev[E_CMP1]  = rise1;
	assign ev[E_CMP2]  = rise2;
	assign ev[E_LTC]   = pin_rise[P_LTC] & ~(dis1 & dis2);
	assign ev[E_HOME]  = pin_rise[P_ORG] & (hom1 | hom2);
	assign ev[E_SLOW]  = pin_rise[P_SD];
	assign ev[E_PULS]  = (pin_chg[P_PA] | pin_chg[P_PB]) & ~pin_q[P_PEN];
	assign ev[E_SSTA]  = pin_rise[P_STA];

	// A read clears only the causes captured for the host at setup; one recorded
	// later stays pending, and an event in the clear cycle wins over the clear
	wire             cause_clr = rd & h_caus;
	wire [MSK_W-1:0] shown     = cause_clr ? prdata_q[MSK_W-1:0] : '0;
	assign cause_d = (cause_q & ~shown) | (ev & mask_q);
	assign irq = |cause_q;

	always_comb begin
		case (env_q[F_SYO+:4])
			SYO_CMP1: sync_d = rise1;
			SYO_CMP2: sync_d = rise2;
			SYO_ACCB: sync_d = motion_ev.accel_begin;
			SYO_ACCF: sync_d = motion_ev.accel_finish;
			SYO_DECB: sync_d = motion_ev.decel_begin;
			SYO_DECF: sync_d = motion_ev.decel_finish;
			default:  sync_d = 1'b0;
		endcase
	end
	assign sync_out     = sync_out_q;
	assign sync_in_used = sync_in_q;

	// Counters read back sign-extended
	always_comb begin
		rd_d = 32'h0;
		case (1'b1)
			h_env:  rd_d[ENV_W-1:0] = env_q;
			h_cnt1: rd_d = {{(32-CW){cnt1[CW-1]}}, cnt1};
			h_cnt2: rd_d = {{(32-CW){cnt2[CW-1]}}, cnt2};
			h_cmp1: rd_d = {{(32-CW){cmp1[CW-1]}}, cmp1};
			h_cmp2: rd_d = {{(32-CW){cmp2[CW-1]}}, cmp2};
			h_mask: rd_d[MSK_W-1:0] = mask_q;
			h_ltc1: rd_d = {{(32-CW){ltc1[CW-1]}}, ltc1};
			h_ltc2: rd_d = {{(32-CW){ltc2[CW-1]}}, ltc2};
			h_caus: rd_d[MSK_W-1:0] = cause_q;
			default: rd_d = 32'h0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			pin_q <= '0;
		end else begin
			s1_q <= pins_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= pin_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			env_q <= '0;
			mask_q <= '0;
			cause_q <= '0;
			prdata_q <= 32'h0;
			sync_out_q <= 1'b0;
			sync_in_q <= 1'b0;
		end else begin
			if (wr & h_env)
				env_q <= pwdata[ENV_W-1:0];
			if (wr & h_mask)
				mask_q <= pwdata[MSK_W-1:0];
			if (setup & ~pwrite)
				prdata_q <= rd_d;
			cause_q <= cause_d;
			sync_out_q <= sync_d;
			sync_in_q <= sync_from_axes[env_q[F_SYI+:2]];
		end
	end

	AST_SRC2: assert property (@(posedge pclk) disable iff (!presetn)
		!env_q[F_SRC2] |-> step2 == encoder_inputs)
		else $error("counter two source wrong");
	AST_MASKED: assert property (@(posedge pclk) disable iff (!presetn)
		!cause_clr && !mask_q[E_STOP] && !cause_q[E_STOP] |=> !cause_q[E_STOP])
		else $error("masked cause recorded");
	AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
		|(ev & mask_q) |=> irq ##0 cause_q == ($past(cause_d)))
		else $error("enabled event gave no interrupt");
	AST_CAUSE_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
		cause_clr && cause_q[E_LTC] && !prdata_q[E_LTC] |=> cause_q[E_LTC])
		else $error("unread cause lost");
	AST_LTC_EV: assert property (@(posedge pclk) disable iff (!presetn)
		dis1 && dis2 |-> !ev[E_LTC])
		else $error("latch event while both disabled");
	AST_HOME_EV: assert property (@(posedge pclk) disable iff (!presetn)
		ev[E_HOME] |-> (hom1 || hom2) && pin_d[P_ORG] && !pin_q[P_ORG])
		else $error("home event without enable");
	AST_PULSER: assert property (@(posedge pclk) disable iff (!presetn)
		pin_q[P_PEN] |-> !ev[E_PULS])
		else $error("pulser event while disabled");
	AST_SYNC_IN: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> sync_in_used == $past(sync_from_axes[env_q[F_SYI+:2]]))
		else $error("sync input select wrong");
	AST_SYNC_CMP: assert property (@(posedge pclk) disable iff (!presetn)
		env_q[F_SYO+:4] == SYO_CMP1 && rise1 |=> sync_out)
		else $error("sync out missed compare");
endmodule

`default_nettype wire

// ===== design/acci_pkg.sv
// Package: register map, field layout and types of the axis counter/compare/event block
// Behaviour
// - Counter 1 counts output pulses when source bit 0 is 0, encoder when 1.
// - Counter 2 counts encoder when source bit 1 is 0, output pulses when 1.
// - Hold bit 2 stops counter 1, hold bit 3 stops counter 2.
// - Bits 4 and 8 clear counter 1 or 2 when it is latched.
// - Bits 5 and 9 stop the external latch input latching counter 1 or 2.
// - Bits 6 and 10 latch and clear counter 1 or 2 on home return done.
// - Bits 7 and 11 make counter 1 or 2 a ring counter bounded by its comparator.
// - Compare method: 00 off, 01 data equals count, 10 data above, 11 data below.
// - Sync output on compare 1 or 2 met, accel start/end, decel start/end codes.
// - Sync input field picks which of four axes supplies the sync signal.
// - Position counters are host writable, readable, signed 28-bit.
// - Compare data registers are host written, signed 28-bit.
// - Mask bits 0..5 enable stop, preregister free, accel and decel events.
// - Mask bits 6 and 7 enable comparator 1 and 2 met events.
// - Mask bit 8 enables external latch event, none when both latch disables set.
// - Mask bit 9 enables home sensor event, none when both home latch bits clear.
// - Mask bit 10 enables slowdown event regardless of slowdown function enable.
// - Mask bit 11 enables pulser change event, suppressed while pulser enable pin high.
// - Mask bit 12 enables simultaneous start event; upper mask bits are zero.
// - A latch copies the counter into its read-only latch holder.
package acci_pkg;
	localparam int CW    = 28;
	localparam int ENV_W = 22;
	localparam int MSK_W = 13;

	localparam logic [7:0] OFS_ENV  = 8'h00;
	localparam logic [7:0] OFS_CNT1 = 8'h04;
	localparam logic [7:0] OFS_CNT2 = 8'h08;
	localparam logic [7:0] OFS_CMP1 = 8'h0C;
	localparam logic [7:0] OFS_CMP2 = 8'h10;
	localparam logic [7:0] OFS_MASK = 8'h14;
	localparam logic [7:0] OFS_LTC1 = 8'h18;
	localparam logic [7:0] OFS_LTC2 = 8'h1C;
	localparam logic [7:0] OFS_CAUS = 8'h20;

	localparam int F_SRC1 = 0;
	localparam int F_SRC2 = 1;
	localparam int F_HLD1 = 2;
	localparam int F_HLD2 = 3;
	localparam int F_CLR1 = 4;
	localparam int F_DIS1 = 5;
	localparam int F_HOM1 = 6;
	localparam int F_RNG1 = 7;
	localparam int F_CLR2 = 8;
	localparam int F_DIS2 = 9;
	localparam int F_HOM2 = 10;
	localparam int F_RNG2 = 11;
	localparam int F_MTH1 = 12;
	localparam int F_MTH2 = 14;
	localparam int F_SYO  = 16;
	localparam int F_SYI  = 20;

	localparam logic [1:0] CMP_EQ = 2'h1;
	localparam logic [1:0] CMP_GT = 2'h2;
	localparam logic [1:0] CMP_LT = 2'h3;

	localparam logic [3:0] SYO_CMP1 = 4'h1;
	localparam logic [3:0] SYO_CMP2 = 4'h2;
	localparam logic [3:0] SYO_ACCB = 4'h8;
	localparam logic [3:0] SYO_ACCF = 4'h9;
	localparam logic [3:0] SYO_DECB = 4'hA;
	localparam logic [3:0] SYO_DECF = 4'hB;

	localparam int E_STOP = 0;
	localparam int E_PREG = 1;
	localparam int E_CMP1 = 6;
	localparam int E_CMP2 = 7;
	localparam int E_LTC  = 8;
	localparam int E_HOME = 9;
	localparam int E_SLOW = 10;
	localparam int E_PULS = 11;
	localparam int E_SSTA = 12;

	// Synchronised pin vector positions
	localparam int P_LTC = 0;
	localparam int P_ORG = 1;
	localparam int P_SD  = 2;
	localparam int P_STA = 3;
	localparam int P_PA  = 4;
	localparam int P_PB  = 5;
	localparam int P_PEN = 6;
	localparam int PINS  = 7;

	typedef struct packed {
		logic up;
		logic down;
	} acci_step_t;

	typedef struct packed {
		logic normal_stop;
		logic prereg_free;
		logic accel_begin;
		logic accel_finish;
		logic decel_begin;
		logic decel_finish;
	} acci_motion_ev_t;
endpackage

// ===== testbench/acci_enc_model.sv
// Encoder side model: emits decoded encoder steps on request
`timescale 1ns/1ps
`default_nettype none

module acci_enc_model
	import acci_pkg::*;
(
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Request
	input  wire logic       go,
	input  wire logic       dir,
	input  wire logic [3:0] n_steps,
	output logic            busy,
	// Decoded steps
	output acci_step_t      enc_step
);
	logic [4:0] left_q;
	logic       dir_q;

	// One step every other cycle, so no two steps ever merge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_q   <= 5'h00;
			dir_q    <= 1'h0;
			enc_step <= '0;
		end else if (go) begin
			left_q <= {n_steps, 1'h0};
			dir_q  <= dir;
		end else begin
			left_q   <= left_q - 5'(left_q != 5'h00);
			enc_step <= (left_q[0] || left_q == 5'h00) ? '0 : {~dir_q, dir_q};
		end
	end

	assign busy = go || left_q != 5'h00;
endmodule

`default_nettype wire

// ===== testbench/tb_axis_counter_compare_irq.sv
// Testbench: registers, counting, latching, comparators, sync select and events
`timescale 1ns/1ps
`default_nettype none

module tb_axis_counter_compare_irq
	import acci_pkg::*;
;
	logic            pclk = 1'h0, presetn = 1'h0;
	logic            psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0]      paddr = 8'h00;
	logic [31:0]     pwdata = 32'h0, prdata, rd;
	logic            pready, pslverr, sync_out, sync_in_used, irq, busy, err;
	acci_step_t      out_step = '0, enc_step;
	acci_motion_ev_t mev = '0;
	logic            home_done = 1'h0, ltc_cmd = 1'h0, pen = 1'h0, go = 1'h0, dir = 1'h0, seen = 1'h0;
	logic [5:0]      pins = 6'h00;
	logic [3:0]      n_steps = 4'h0, axes = 4'h0;
	int              error_cnt = 0, compares = 0, i;

	acci_counter_compare_irq DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .out_pulse_step(out_step), .encoder_inputs(enc_step), .motion_ev(mev),
		.home_return_done(home_done), .latch_command(ltc_cmd), .external_latch_input(pins[0]),
		.home_sensor_input(pins[1]), .slowdown_input(pins[2]), .simultaneous_start_input(pins[3]),
		.pulser_inputs(pins[5:4]), .pulser_enable_pin(pen), .sync_from_axes(axes), .sync_out,
		.sync_in_used, .irq);
	acci_enc_model MODEL (.pclk, .presetn, .go, .dir, .n_steps, .busy, .enc_step);

	initial begin
		forever #25 pclk = ~pclk;
	end

	// Sync output is a one-cycle pulse, so it is caught here
	always @(posedge pclk) begin
		if (sync_out === 1'h1)
			seen <= 1'h1;
	end

	task automatic summarize;
		$display("Errors %0d, compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		for (k = 0; k < 16; k++) begin
			@(posedge pclk);
			if (pready === 1'h1)
				break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (k == 16) begin
			error_cnt++;
			$display("Error at %0t: bus transfer never ended", $time);
			summarize();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0);
		chk(rd, exp);
	endtask

	task automatic steps(input int n, input logic dn);
		repeat (n) begin
			@(posedge pclk);
			out_step <= dn ? 2'h1 : 2'h2;
			@(posedge pclk);
			out_step <= '0;
		end
	endtask

	task automatic enc(input logic [3:0] n, input logic dn);
		int k;
		@(posedge pclk);
		go <= 1'h1;
		n_steps <= n;
		dir <= dn;
		@(posedge pclk);
		go <= 1'h0;
		for (k = 0; k < 64; k++) begin
			@(posedge pclk);
			if (busy === 1'h0)
				break;
		end
		chk({31'h0, busy}, 32'h0);
	endtask

	task automatic wait_irq(input logic exp);
		for (int k = 0; k < 12; k++) begin
			@(posedge pclk);
			if (irq === 1'h1)
				break;
		end
		chk({31'h0, irq}, {31'h0, exp});
	endtask

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		rdc(OFS_ENV, 32'h0);
		rdc(OFS_CAUS, 32'h0);
		apb(1'h0, 8'h40, 32'h0);
		chk({rd[31:1], err}, 32'h1);
		apb(1'h1, OFS_LTC1, 32'h5);
		chk({31'h0, err}, 32'h1);
		rdc(OFS_LTC1, 32'h0);
		wr(OFS_CNT1, 32'h0800_0000);
		rdc(OFS_CNT1, 32'hF800_0000);
		wr(OFS_CNT2, 32'h07FF_FFFF);
		rdc(OFS_CNT2, 32'h07FF_FFFF);
		wr(OFS_CMP1, 32'h0800_0000);
		rdc(OFS_CMP1, 32'hF800_0000);
		wr(OFS_MASK, 32'hFFFF_FFFF);
		rdc(OFS_MASK, 32'h0000_1FFF);
		// Count sources and hold
		wr(OFS_ENV, 32'h0);
		wr(OFS_CNT1, 32'h0);
		wr(OFS_CNT2, 32'h0);
		steps(3, 1'h0);
		enc(4'h2, 1'h0);
		rdc(OFS_CNT1, 32'h3);
		rdc(OFS_CNT2, 32'h2);
		wr(OFS_ENV, 32'h3);
		steps(1, 1'h1);
		enc(4'h2, 1'h1);
		rdc(OFS_CNT1, 32'h1);
		rdc(OFS_CNT2, 32'h1);
		wr(OFS_ENV, 32'hF);
		steps(1, 1'h0);
		enc(4'h1, 1'h0);
		rdc(OFS_CNT1, 32'h1);
		rdc(OFS_CNT2, 32'h1);
		// Ring counter bounded by compare value 3
		wr(OFS_ENV, 32'h80);
		wr(OFS_CMP1, 32'h3);
		wr(OFS_CNT1, 32'h0);
		steps(4, 1'h0);
		rdc(OFS_CNT1, 32'h0);
		steps(1, 1'h1);
		rdc(OFS_CNT1, 32'h3);
		// External latch clears counter 1, counter 2 latch disabled
		wr(OFS_ENV, 32'h210);
		wr(OFS_CNT1, 32'h5);
		wr(OFS_CNT2, 32'h7);
		wr(OFS_MASK, 32'h100);
		pins[0] <= 1'h1;
		wait_irq(1'h1);
		rdc(OFS_CAUS, 32'h100);
		@(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		rdc(OFS_LTC1, 32'h5);
		rdc(OFS_CNT1, 32'h0);
		rdc(OFS_LTC2, 32'h0);
		pins[0] <= 1'h0;
		wr(OFS_ENV, 32'h220);
		pins[0] <= 1'h1;
		wait_irq(1'h0);
		pins[0] <= 1'h0;
		// Home return completion and latch command
		wr(OFS_ENV, 32'h440);
		wr(OFS_CNT1, 32'h9);
		wr(OFS_CNT2, 32'h6);
		home_done <= 1'h1;
		@(posedge pclk);
		home_done <= 1'h0;
		rdc(OFS_LTC1, 32'h9);
		rdc(OFS_CNT2, 32'h0);
		wr(OFS_ENV, 32'h10);
		wr(OFS_CNT2, 32'h4);
		ltc_cmd <= 1'h1;
		@(posedge pclk);
		ltc_cmd <= 1'h0;
		rdc(OFS_LTC2, 32'h4);
		rdc(OFS_CNT2, 32'h4);
		// Every comparator method against counter 2 at 10
		wr(OFS_CNT2, 32'hA);
		wr(OFS_MASK, 32'h80);
		for (i = 0; i < 4; i++) begin
			wr(OFS_ENV, 32'h0);
			wr(OFS_CMP2, 32'(i == 2 ? 11 : i == 3 ? 9 : 10));
			apb(1'h0, OFS_CAUS, 32'h0);
			seen <= 1'h0;
			wr(OFS_ENV, 32'(i) << 14 | 32'h0002_0000);
			rdc(OFS_CAUS, i == 0 ? 32'h0 : 32'h80);
			chk({31'h0, seen}, {31'h0, i != 0});
		end
		// Comparator 1 met drives the sync output
		wr(OFS_CNT1, 32'h4);
		wr(OFS_CMP1, 32'h5);
		wr(OFS_MASK, 32'h40);
		wr(OFS_ENV, 32'h0001_1000);
		apb(1'h0, OFS_CAUS, 32'h0);
		seen <= 1'h0;
		steps(1, 1'h0);
		repeat (3) @(posedge pclk);
		chk({31'h0, seen}, 32'h1);
		rdc(OFS_CAUS, 32'h40);
		// Motion events, with sync codes on the accel and decel ones
		for (i = 0; i < 6; i++) begin
			wr(OFS_MASK, 32'h1 << i);
			wr(OFS_ENV, i > 1 ? 32'(i + 6) << 16 : 32'h0);
			seen <= 1'h0;
			@(posedge pclk);
			mev <= acci_motion_ev_t'(6'h20 >> i);
			@(posedge pclk);
			mev <= '0;
			repeat (3) @(posedge pclk);
			chk({31'h0, seen}, {31'h0, i > 1});
			rdc(OFS_CAUS, 32'h1 << i);
		end
		// Sync input axis select
		for (i = 0; i < 4; i++) begin
			wr(OFS_ENV, 32'(i) << 20);
			axes <= 4'h1 << i;
			repeat (3) @(posedge pclk);
			chk({31'h0, sync_in_used}, 32'h1);
			axes <= ~(4'h1 << i);
			repeat (3) @(posedge pclk);
			chk({31'h0, sync_in_used}, 32'h0);
		end
		// Pulser change is suppressed while the enable pin is high
		wr(OFS_ENV, 32'h40);
		pen <= 1'h1;
		wr(OFS_MASK, 32'h800);
		pins[4] <= 1'h1;
		wait_irq(1'h0);
		pins[4] <= 1'h0;
		repeat (6) @(posedge pclk);
		pen <= 1'h0;
		repeat (6) @(posedge pclk);
		// Each pin event with its own mask bit
		for (i = 0; i < 6; i++) begin
			wr(OFS_MASK, 32'h1 << (i == 3 ? 12 : i >= 4 ? 11 : 8 + i));
			pins[i] <= 1'h1;
			wait_irq(1'h1);
			rdc(OFS_CAUS, 32'h1 << (i == 3 ? 12 : i >= 4 ? 11 : 8 + i));
			wr(OFS_MASK, 32'h0);
			pins[i] <= 1'h0;
			repeat (6) @(posedge pclk);
		end
		summarize();
	end
endmodule

`default_nettype wire
